// [sps_far_model.sv]
// Far-side model: primary controller state and one secondary path cell.
`timescale 1ns/1ns
module sps_far_model
    import sps_pkg::*;
(
    input wire logic tck, // Test clock.
    input wire logic tms, // Mode select from the controller.
    input wire logic sec_in, // Serial data leaving the selector.
    output sps_tap_e state, // Controller state.
    output logic sec_out // Serial data back to the selector.
);
    // The controller walks the standard diagram just after each rising edge.
    initial state = ST_RESET;
    always @(posedge tck) begin
        state <= #1 sps_tap_next(state, tms);
    end
    // One secondary cell, so a selected path adds its own bit of delay.
    initial sec_out = 1'b0;
    always @(posedge tck) begin
        sec_out <= #1 sec_in;
    end
endmodule

// [sps_pkg.sv]
// Package of constants, states and helpers for the scan path selector.
package sps_pkg;
    // Register widths.
    localparam int PS_W = 8;
    localparam int BND_W = 15;
    localparam int IDB_W = 8;
    localparam int CNT_W = 8;
    localparam int RIR_W = 8;
    // Reset and capture values.
    localparam logic [7:0] PS_RESET = 8'h00;
    localparam logic [7:0] CNT_SHIFT_RESET = 8'h00;
    localparam logic [7:0] RIR_RESET = 8'hFF;
    localparam logic [7:0] RIR_CAPTURE = 8'h01;
    localparam logic [3:0] SEC_ALL_HIGH = 4'hF;
    // Remote port opcode that routes the path-select register.
    localparam logic [7:0] RIR_SCAN_PS = 8'h7E;
    // Counter end values.
    localparam logic [7:0] CNT_MIN = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    // Per-output path-select section codes.
    localparam logic [1:0] SEC_HIGH = 2'h0;
    localparam logic [1:0] SEC_LOW = 2'h1;
    localparam logic [1:0] SEC_REMOTE = 2'h2;
    localparam logic [1:0] SEC_PRIMARY = 2'h3;
    // Condition output source selection.
    localparam logic [1:0] COND_STATIC = 2'h0;
    localparam logic [1:0] COND_PATH_ERR = 2'h1;
    localparam logic [1:0] COND_COUNT = 2'h2;
    localparam logic [1:0] COND_INPUT = 2'h3;
    // Boundary cell positions.
    localparam int BND_MCI = 14;
    localparam int BND_MCO = 13;
    localparam int BND_COND_IN = 12;
    localparam int BND_TS_EN = 11;
    localparam int BND_OD_EN = 10;
    localparam int BND_COND_OUT = 9;
    localparam int BND_IDB_OE = 8;
    localparam int BND_ID_TOP = 7;

    // Test access port controller states.
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR,
        ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
        ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
        ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sps_tap_e;

    // Standard state diagram step for one mode-select sample.
    function automatic sps_tap_e sps_tap_next(input sps_tap_e s,
                                               input logic m);
        case (s)
            ST_RESET: sps_tap_next = m ? ST_RESET : ST_IDLE;
            ST_IDLE: sps_tap_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: sps_tap_next = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: sps_tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: sps_tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: sps_tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: sps_tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: sps_tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: sps_tap_next = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: sps_tap_next = m ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: sps_tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: sps_tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: sps_tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: sps_tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: sps_tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: sps_tap_next = m ? ST_SEL_DR : ST_IDLE;
            default: sps_tap_next = ST_RESET;
        endcase
    endfunction

    // Section MSBs of a path-select value, one per secondary output.
    function automatic logic [3:0] sps_msbs(input logic [7:0] v);
        sps_msbs = {v[7], v[5], v[3], v[1]};
    endfunction

    // High when at most one section asks to follow.
    function automatic logic sps_valid(input logic [7:0] v);
        logic [3:0] m;
        m = sps_msbs(v);
        sps_valid = $onehot0(m);
    endfunction
endpackage

// [sps_scan_select.sv]
// Data registers and remote port of the scan path selector.
// Notes on behaviour
// - At most one secondary output follows a source.
// - Path error low when two section MSBs set.
// - Path error shown on condition output in Pause-DR.
// - Invalid value at Update-DR forces outputs high.
// - Static levels apply at Update-DR falling edge.
// - Follow moves between outputs at Update-DR edge.
// - First follow starts at Run-Test/Idle falling edge.
// - Section code: high, low, remote, primary follow.
// - Path select is four 2-bit sections, resets zero.
// - Boundary register has fifteen cells in fixed order.
// - Reset leaves boundary contents untouched.
// - ID-bus cells scan alone without other cells.
// - Bypass bit sits in the path by default.
// - Bypass keeps a selected secondary path inserted.
// - Counter preloads and scans out; reset clears shift.
// - Condition input edge clocks counter, edge selectable.
// - End flag low at zero down or full up.
// - Direction select and stop-at-zero while down.
// - Control bits route end flag to condition output.
// - Remote port runs the state diagram when enabled.
// - Remote port has 8-bit instruction register.
// - Opcode 01111110 selects path select, else bypass.
`timescale 1ns/1ns
module sps_scan_select
    import sps_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic tck, // Test clock.
    input wire sps_tap_e primary_state, // Primary port state.
    input wire logic tdi, // Primary serial data in.
    input wire logic tms, // Primary mode select.
    input wire logic remote_mode_select, // Remote mode select.
    input wire logic sel_path_select, // Primary selects path select.
    input wire logic sel_boundary, // Primary selects boundary.
    input wire logic sel_id_bus, // Primary selects ID-bus cells.
    input wire logic sel_counter, // Primary selects counter.
    input wire logic ctl_remote_en, // Remote port enable.
    input wire logic ctl_count_down, // Count down when set.
    input wire logic ctl_stop_zero, // Hold at zero counting down.
    input wire logic ctl_cond_neg, // Count on falling edge.
    input wire logic [1:0] ctl_cond_sel, // Condition output source.
    input wire logic ctl_cond_invert, // Invert condition output.
    input wire logic ctl_cond_gate, // Masks path error source.
    input wire logic condition_in, // Condition input pin.
    input wire logic secondary_data_in, // Secondary data in.
    input wire logic [14:0] bnd_capture, // Pin levels to capture.
    output logic tdo, // Primary serial data out.
    output logic secondary_data_out, // Secondary data out.
    output logic [3:0] secondary_mode_select, // Secondary selects.
    output logic condition_out, // Condition output level.
    output logic [14:0] bnd_drive, // Boundary update stage.
    output logic sys_path_error_n, // Path error, system side.
    output logic sys_count_end_n // End of count, system side.
);

    logic rst_meta;
    logic rst_tck_n;
    logic dci_meta;
    logic dci_s;
    logic dci_d;
    logic cnt_evt;
    sps_tap_e rem_st;
    sps_tap_e acc_st;
    logic [7:0] rem_ir;
    logic [7:0] rem_ir_shift;
    logic rem_byp;
    logic rem_lsb;
    logic ps_sel;
    logic ps_in;
    logic pri_in;
    logic [7:0] ps_shift;
    logic [7:0] ps_upd;
    logic ps_upd_now;
    logic forced;
    logic follow_live;
    logic path_error_n;
    logic [7:0] eff_cfg;
    logic eff_force;
    logic eff_live;
    logic [3:0] next_sec;
    logic [14:0] bnd_shift;
    logic [14:0] bnd_cap;
    logic byp;
    logic sdo_pipe;
    logic [7:0] cnt_shift;
    logic [7:0] event_cnt;
    logic cnt_load;
    logic count_end_n;
    logic next_cond;
    logic next_tdo;
    logic pe_q;
    logic ce_q;
    logic pe_meta;
    logic ce_meta;

    // Reset carried into the test clock domain.
    always_ff @(posedge tck) begin
        rst_meta <= nrst;
        rst_tck_n <= rst_meta;
    end

    // Condition input synchroniser and edge stage.
    always_ff @(posedge tck) begin
        dci_meta <= condition_in;
        dci_s <= dci_meta;
        dci_d <= dci_s;
    end

    // Selected edge of the condition input is one count event.
    assign cnt_evt = ctl_cond_neg ? (dci_d & ~dci_s)
                                  : (dci_s & ~dci_d);

    // Remote controller state, held in reset while disabled.
    always_ff @(posedge tck) begin
        if (!rst_tck_n || !ctl_remote_en) begin
            rem_st <= ST_RESET;
        end else begin
            rem_st <= sps_tap_next(rem_st, remote_mode_select);
        end
    end

    // Remote instruction shift stage.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            rem_ir_shift <= RIR_CAPTURE;
        end else if (rem_st == ST_CAP_IR) begin
            rem_ir_shift <= RIR_CAPTURE;
        end else if (rem_st == ST_SHIFT_IR) begin
            rem_ir_shift <= {secondary_data_in, rem_ir_shift[7:1]};
        end
    end

    // Remote instruction update stage.
    always_ff @(posedge tck) begin
        if (!rst_tck_n || rem_st == ST_RESET) begin
            rem_ir <= RIR_RESET;
        end else if (rem_st == ST_UPD_IR) begin
            rem_ir <= rem_ir_shift;
        end
    end

    // Remote bypass bit, used for every opcode but one.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            rem_byp <= 1'b0;
        end else if (rem_st == ST_CAP_DR) begin
            rem_byp <= 1'b0;
        end else if (rem_st == ST_SHIFT_DR) begin
            rem_byp <= secondary_data_in;
        end
    end

    // Owner of the path-select register and its serial input.
    assign ps_sel = ctl_remote_en ? (rem_ir == RIR_SCAN_PS)
                                  : sel_path_select;
    assign acc_st = ctl_remote_en ? rem_st : primary_state;
    assign pri_in = (follow_live && !ctl_remote_en)
                    ? secondary_data_in : tdi;
    assign ps_in = ctl_remote_en ? secondary_data_in : pri_in;
    assign ps_upd_now = ps_sel && (acc_st == ST_UPD_DR);
    assign path_error_n = sps_valid(ps_shift);
    assign rem_lsb = (rem_st == ST_SHIFT_IR) ? rem_ir_shift[0]
                   : (ps_sel ? ps_shift[0] : rem_byp);

    // Path-select shift stage, captures the applied value.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            ps_shift <= PS_RESET;
        end else if (ps_sel && acc_st == ST_CAP_DR) begin
            ps_shift <= ps_upd;
        end else if (ps_sel && acc_st == ST_SHIFT_DR) begin
            ps_shift <= {ps_in, ps_shift[7:1]};
        end
    end

    // Applied value, error force and follow state on falling edges.
    always_ff @(negedge tck) begin
        if (!rst_tck_n) begin
            ps_upd <= PS_RESET;
            forced <= 1'b0;
            follow_live <= 1'b0;
        end else if (ps_upd_now) begin
            ps_upd <= ps_shift;
            forced <= !path_error_n;
            follow_live <= follow_live && path_error_n
                           && (|sps_msbs(ps_shift));
        end else if (acc_st == ST_IDLE && !forced
                     && (|sps_msbs(ps_upd))) begin
            follow_live <= 1'b1;
        end
    end

    // Level each secondary output takes at the next falling edge.
    always_comb begin
        eff_cfg = ps_upd_now ? ps_shift : ps_upd;
        eff_force = ps_upd_now ? !path_error_n : forced;
        eff_live = ps_upd_now ? follow_live
                 : (follow_live || (acc_st == ST_IDLE && !forced));
        for (int i = 0; i < 4; i++) begin
            case (eff_cfg[2*i+1 -: 2])
                SEC_HIGH: next_sec[i] = 1'b1;
                SEC_LOW: next_sec[i] = 1'b0;
                SEC_REMOTE: next_sec[i] = eff_live ? remote_mode_select
                                        : secondary_mode_select[i];
                SEC_PRIMARY: next_sec[i] = eff_live ? tms
                                         : secondary_mode_select[i];
                default: next_sec[i] = 1'b1;
            endcase
            if (eff_force) begin
                next_sec[i] = 1'b1;
            end
        end
    end

    // Secondary mode-select outputs change on falling edges.
    always_ff @(negedge tck) begin
        if (!rst_tck_n) begin
            secondary_mode_select <= SEC_ALL_HIGH;
        end else begin
            secondary_mode_select <= next_sec;
        end
    end

    // Boundary capture picks up live condition levels.
    always_comb begin
        bnd_cap = bnd_capture;
        bnd_cap[BND_COND_IN] = dci_s;
        bnd_cap[BND_COND_OUT] = condition_out;
    end

    // Boundary and ID-bus shift stage, untouched by reset.
    always_ff @(posedge tck) begin
        if (sel_boundary && primary_state == ST_CAP_DR) begin
            bnd_shift <= bnd_cap;
        end else if (sel_boundary && primary_state == ST_SHIFT_DR) begin
            bnd_shift <= {pri_in, bnd_shift[14:1]};
        end else if (sel_id_bus && primary_state == ST_CAP_DR) begin
            bnd_shift[BND_ID_TOP:0] <= bnd_cap[BND_ID_TOP:0];
        end else if (sel_id_bus && primary_state == ST_SHIFT_DR) begin
            bnd_shift[BND_ID_TOP:0] <=
                {pri_in, bnd_shift[BND_ID_TOP:1]};
        end
    end

    // Boundary update stage, also untouched by reset.
    always_ff @(negedge tck) begin
        if (primary_state == ST_UPD_DR && sel_boundary) begin
            bnd_drive <= bnd_shift;
        end else if (primary_state == ST_UPD_DR && sel_id_bus) begin
            bnd_drive[BND_ID_TOP:0] <= bnd_shift[BND_ID_TOP:0];
        end
    end

    // Primary bypass bit.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            byp <= 1'b0;
        end else if (primary_state == ST_CAP_DR) begin
            byp <= 1'b0;
        end else if (primary_state == ST_SHIFT_DR) begin
            byp <= pri_in;
        end
    end

    // One bit of delay from the primary input to the secondary path.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            sdo_pipe <= 1'b0;
        end else begin
            sdo_pipe <= tdi;
        end
    end

    // Secondary data output on falling edges.
    always_ff @(negedge tck) begin
        if (!rst_tck_n) begin
            secondary_data_out <= 1'b0;
        end else begin
            secondary_data_out <= ctl_remote_en ? rem_lsb : sdo_pipe;
        end
    end

    // Counter shift stage, cleared by reset.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            cnt_shift <= CNT_SHIFT_RESET;
        end else if (sel_counter && primary_state == ST_CAP_DR) begin
            cnt_shift <= event_cnt;
        end else if (sel_counter && primary_state == ST_SHIFT_DR) begin
            cnt_shift <= {pri_in, cnt_shift[7:1]};
        end
    end

    assign cnt_load = sel_counter && (primary_state == ST_UPD_DR);

    // Event counter, kept through reset.
    always_ff @(posedge tck) begin
        if (cnt_load) begin
            event_cnt <= cnt_shift;
        end else if (cnt_evt && ctl_count_down) begin
            if (!(ctl_stop_zero && event_cnt == CNT_MIN)) begin
                event_cnt <= event_cnt - 8'h01;
            end
        end else if (cnt_evt) begin
            event_cnt <= event_cnt + 8'h01;
        end
    end

    // End-of-count flag, active low.
    assign count_end_n = ctl_count_down ? (event_cnt != CNT_MIN)
                                        : (event_cnt != CNT_MAX);

    // Condition output source selection.
    always_comb begin
        case (ctl_cond_sel)
            COND_STATIC: next_cond = 1'b1;
            COND_PATH_ERR: next_cond = ctl_cond_gate
                || !(primary_state == ST_PAUSE_DR && !path_error_n);
            COND_COUNT: next_cond = count_end_n;
            COND_INPUT: next_cond = dci_s ^ ctl_cond_neg;
            default: next_cond = 1'b1;
        endcase
    end

    // Condition output changes on falling edges.
    always_ff @(negedge tck) begin
        if (!rst_tck_n) begin
            condition_out <= 1'b1;
        end else begin
            condition_out <= next_cond ^ ctl_cond_invert;
        end
    end

    // Primary serial output, bypass unless another path is selected.
    always_comb begin
        if (sel_boundary || sel_id_bus) begin
            next_tdo = bnd_shift[0];
        end else if (sel_counter) begin
            next_tdo = cnt_shift[0];
        end else if (sel_path_select && !ctl_remote_en) begin
            next_tdo = ps_shift[0];
        end else begin
            next_tdo = byp;
        end
    end

    always_ff @(negedge tck) begin
        if (!rst_tck_n) begin
            tdo <= 1'b0;
        end else begin
            tdo <= next_tdo;
        end
    end

    // Flags registered in the test domain before crossing.
    always_ff @(posedge tck) begin
        if (!rst_tck_n) begin
            pe_q <= 1'b1;
            ce_q <= 1'b1;
        end else begin
            pe_q <= path_error_n;
            ce_q <= count_end_n;
        end
    end

    // Two-stage synchronisers into the system clock.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pe_meta <= 1'b1;
            ce_meta <= 1'b1;
            sys_path_error_n <= 1'b1;
            sys_count_end_n <= 1'b1;
        end else begin
            pe_meta <= pe_q;
            ce_meta <= ce_q;
            sys_path_error_n <= pe_meta;
            sys_count_end_n <= ce_meta;
        end
    end

    // Invalid value at update forces all outputs high.
    property p_force;
        @(negedge tck) disable iff (!rst_tck_n)
        (ps_upd_now && !path_error_n) |=> secondary_mode_select == 4'hF;
    endproperty
    a_force: assert property (p_force)
        else $error("outputs not forced high");

    // No two outputs follow at once.
    property p_one;
        @(negedge tck) disable iff (!rst_tck_n)
        follow_live |-> $onehot0(sps_msbs(ps_upd) & {4{!forced}});
    endproperty
    a_one: assert property (p_one)
        else $error("more than one output follows");

    // Static low takes effect at the update edge.
    property p_static;
        @(negedge tck) disable iff (!rst_tck_n)
        (ps_upd_now && path_error_n && ps_shift[1:0] == SEC_LOW)
        |=> !secondary_mode_select[0];
    endproperty
    a_static: assert property (p_static)
        else $error("static level late");

    // First follow waits for idle.
    property p_wait;
        @(negedge tck) disable iff (!rst_tck_n)
        (ps_upd_now && !follow_live) |=> !follow_live;
    endproperty
    a_wait: assert property (p_wait)
        else $error("follow began before idle");

    // Follow carries over at update.
    property p_move;
        @(negedge tck) disable iff (!rst_tck_n)
        (ps_upd_now && follow_live && path_error_n
         && (|sps_msbs(ps_shift))) |=> follow_live;
    endproperty
    a_move: assert property (p_move)
        else $error("follow lost on transfer");

    // End flag tracks the counter end value.
    property p_end;
        @(posedge tck) disable iff (!rst_tck_n)
        (ctl_count_down && event_cnt == CNT_MIN) |=> !ce_q;
    endproperty
    a_end: assert property (p_end)
        else $error("end flag missing");

    // Stop-at-zero holds the counter.
    property p_stop;
        @(posedge tck) disable iff (!rst_tck_n)
        (ctl_count_down && ctl_stop_zero && event_cnt == CNT_MIN
         && !cnt_load) |=> event_cnt == CNT_MIN;
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter left zero");

    // Remote scan opcode shifts into the path-select register.
    property p_rscan;
        @(posedge tck) disable iff (!rst_tck_n)
        (ctl_remote_en && rem_ir == RIR_SCAN_PS && rem_st == ST_SHIFT_DR)
        |=> ps_shift[7] == $past(secondary_data_in);
    endproperty
    a_rscan: assert property (p_rscan)
        else $error("remote scan path wrong");

endmodule

// [tb.sv]
// Self-checking bench for the scan path selector data registers.
`timescale 1ns/1ns
module tb;
    import sps_pkg::*;
    logic sys_clk = 1'b0;
    logic tck = 1'b0;
    logic nrst = 1'b0;
    logic tms = 1'b1;
    logic rms = 1'b1;
    logic tdi = 1'b0;
    logic sdi_tb = 1'b0;
    logic use_rem = 1'b0;
    logic sel_ps = 1'b0;
    logic sel_cnt = 1'b0;
    logic rem_en = 1'b0;
    logic cnt_down = 1'b0;
    logic stop_zero = 1'b0;
    logic cond_neg = 1'b0;
    logic sel_bnd = 1'b0;
    logic sel_idb = 1'b0;
    logic [1:0] cond_sel = 2'h1;
    logic cond_in = 1'b0;
    logic [14:0] bnd_cap = 15'h0000;
    logic tdo, sdo, cond_out, perr_n, cend_n, cell_out, sdi;
    logic [3:0] sms;
    logic [14:0] bnd_drv;
    sps_tap_e pstate;
    int error_cnt = 0;
    int checked = 0;
    integer seed = 28063;
    logic [7:0] v;
    logic [14:0] bnd_exp;

    // Clocks: 125 MHz system clock and a 15 ns test clock.
    always #4 sys_clk = ~sys_clk;
    always begin
        #7 tck = 1'b1;
        #8 tck = 1'b0;
    end
    // The remote controller feeds the secondary input when enabled.
    assign sdi = rem_en ? sdi_tb : cell_out;

    sps_far_model i_far (.tck(tck), .tms(tms), .sec_in(sdo),
        .state(pstate), .sec_out(cell_out));
    sps_scan_select i_dut (.sys_clk(sys_clk), .nrst(nrst), .tck(tck),
        .primary_state(pstate), .tdi(tdi), .tms(tms),
        .remote_mode_select(rms), .sel_path_select(sel_ps),
        .sel_boundary(sel_bnd), .sel_id_bus(sel_idb), .sel_counter(sel_cnt),
        .ctl_remote_en(rem_en), .ctl_count_down(cnt_down),
        .ctl_stop_zero(stop_zero), .ctl_cond_neg(cond_neg),
        .ctl_cond_sel(cond_sel), .ctl_cond_invert(1'b0),
        .ctl_cond_gate(1'b0), .condition_in(cond_in),
        .secondary_data_in(sdi), .bnd_capture(bnd_cap), .tdo(tdo),
        .secondary_data_out(sdo), .secondary_mode_select(sms),
        .condition_out(cond_out), .bnd_drive(bnd_drv),
        .sys_path_error_n(perr_n), .sys_count_end_n(cend_n));

    // Static sections drive the inverse of their low bit.
    function automatic logic [3:0] exp_static(input logic [7:0] x);
        for (int i = 0; i < 4; i++) exp_static[i] = ~x[2 * i];
    endfunction

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One test clock with the chosen mode select and serial data.
    task automatic tk(input logic m, input logic d);
        if (use_rem) rms = m;
        else tms = m;
        tdi = d;
        sdi_tb = d;
        @(posedge tck);
        #1;
    endtask

    // Scans n bits LSB first from Idle and stops in the update state.
    task automatic scan(input logic ir, input logic [7:0] val,
                        input int n, input logic pz);
        tk(1'b1, 1'b0);
        if (ir) tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
        tk(1'b0, 1'b0);
        for (int i = 0; i < n; i++) tk(i == n - 1, val[i % 8]);
        if (pz) begin
            repeat (4) tk(1'b0, 1'b0);
            chk("cond_out", 8'(cond_out), 8'h00);
            chk("path_err", 8'(perr_n), 8'h00);
            tk(1'b1, 1'b0);
        end
        tk(1'b1, 1'b0);
        if (use_rem) rms = 1'b0;
        else tms = 1'b0;
    endtask

    // Raises and drops the condition input once.
    task automatic pulse();
        cond_in = 1'b1;
        repeat (5) @(posedge tck);
        #1 cond_in = 1'b0;
        repeat (6) @(posedge tck);
        #1;
    endtask

    // Loads the counter and lets it see two events.
    task automatic count2(input logic [7:0] val, input logic [7:0] e1,
                          input logic [7:0] e2);
        sel_cnt = 1'b1;
        scan(1'b0, val, 8, 1'b0);
        tk(1'b0, 1'b0);
        sel_cnt = 1'b0;
        // The end flag needs a test clock and two system clocks to cross.
        repeat (3) tk(1'b0, 1'b0);
        chk("end_load", 8'(cend_n), 8'h01);
        chk("tdo_byp", 8'(tdo), 8'(val[7]));
        pulse();
        chk("end_one", 8'(cend_n), e1);
        pulse();
        chk("end_two", 8'(cend_n), e2);
    endtask

    // Guards against a hang.
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        bnd_cap = 15'($random(seed));
        repeat (10) @(posedge sys_clk);
        chk("sms_rst", 8'(sms), 8'h0F);
        chk("end_rst", 8'(cend_n), 8'h01);
        #1 nrst = 1'b1;
        repeat (4) @(posedge tck);
        #1;
        tk(1'b0, 1'b0);
        count2(8'hFE, 8'h00, 8'h01);
        cnt_down = 1'b1;
        stop_zero = 1'b1;
        count2(8'h01, 8'h00, 8'h00);
        cnt_down = 1'b0;
        stop_zero = 1'b0;
        cond_neg = 1'b1;
        count2(8'hFD, 8'h01, 8'h00);
        // Full boundary scan, then the ID-bus cells on their own.
        v = 8'($random(seed));
        sel_bnd = 1'b1;
        scan(1'b0, v, 15, 1'b0);
        @(negedge tck);
        #1;
        chk("bnd_lo", bnd_drv[7:0], v);
        chk("bnd_hi", 8'(bnd_drv[14:8]), 8'(v[6:0]));
        sel_bnd = 1'b0;
        sel_idb = 1'b1;
        scan(1'b0, ~v, 8, 1'b0);
        @(negedge tck);
        #1;
        chk("idb_lo", bnd_drv[7:0], ~v);
        chk("idb_hi", 8'(bnd_drv[14:8]), 8'(v[6:0]));
        bnd_exp = {v[6:0], ~v};
        sel_idb = 1'b0;
        tk(1'b0, 1'b0);
        sel_ps = 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h55 : 8'($random(seed)) & 8'h55;
            scan(1'b0, v, 8, 1'b0);
            @(negedge tck);
            #1;
            chk("sms_static", 8'(sms), 8'(exp_static(v)));
            tk(1'b0, 1'b0);
        end
        // Let the final error level cross into the system clock.
        tk(1'b0, 1'b0);
        chk("path_ok", 8'(perr_n), 8'h01);
        rms = 1'b0;
        scan(1'b0, 8'h02, 8, 1'b0);
        @(negedge tck);
        #1;
        chk("sms_pend", 8'(sms), 8'({3'h7, ~v[0]}));
        tk(1'b0, 1'b0);
        @(negedge tck);
        #1;
        chk("sms_first", 8'(sms), 8'h0E);
        scan(1'b0, 8'h0C, 10, 1'b0);
        @(negedge tck);
        #1;
        chk("sms_move", 8'(sms), 8'h0D);
        tk(1'b0, 1'b0);
        scan(1'b0, 8'hA0, 10, 1'b1);
        @(negedge tck);
        #1;
        chk("sms_bad", 8'(sms), 8'h0F);
        tk(1'b0, 1'b0);
        rms = 1'b1;
        rem_en = 1'b1;
        use_rem = 1'b1;
        tk(1'b1, 1'b0);
        tk(1'b1, 1'b0);
        tk(1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            scan(1'b1, (i == 0) ? 8'h7E : 8'hFF, 8, 1'b0);
            tk(1'b0, 1'b0);
            scan(1'b0, (i == 0) ? 8'h44 : 8'h11, 8, 1'b0);
            @(negedge tck);
            #1;
            chk("sms_remote", 8'(sms), 8'h05);
            tk(1'b0, 1'b0);
        end
        // A reset in mid-run clears path select but keeps boundary cells.
        nrst = 1'b0;
        repeat (5) @(posedge tck);
        #1;
        chk("sms_rst2", 8'(sms), 8'h0F);
        chk("bnd_hold", bnd_drv[7:0], bnd_exp[7:0]);
        chk("bnd_hold_hi", 8'(bnd_drv[14:8]), 8'(bnd_exp[14:8]));
        give_verdict();
    end
endmodule
